// ==== pkg/adto_defs.svh ====
// register offsets, field positions, reset values and timing figures of the dead-time block
`ifndef ADTO_DEFS_SVH
`define ADTO_DEFS_SVH

// register indices; byte address is four times the index
`define ADTO_IDX_THRESHOLD 8'h68
`define ADTO_IDX_EDGE_OFFSETS 8'h69
`define ADTO_IDX_STATUS 8'h70

// threshold register fields
`define ADTO_THR_CODE_MSB 2
`define ADTO_THR_CODE_LSB 0
`define ADTO_THR_RESET 8'h00

// edge offset register fields
`define ADTO_E1_POL_BIT 7
`define ADTO_E1_MAG_MSB 6
`define ADTO_E1_MAG_LSB 4
`define ADTO_E2_POL_BIT 3
`define ADTO_E2_MAG_MSB 2
`define ADTO_E2_MAG_LSB 0
`define ADTO_OFFSETS_RESET 8'h00

// status register fields
`define ADTO_ST_APPLIED_BIT 0
`define ADTO_ST_BELOW_BIT 1

// sense scale: full-scale 8-bit reading is the selected sense range
`define ADTO_THR_STEP 8'h1a

// offset step and the time unit of the edge-time words
`define ADTO_STEP_NS 5
`define ADTO_TICK_NS 5
`define ADTO_STEP_TICKS (`ADTO_STEP_NS / `ADTO_TICK_NS)

// avalon answers
`define ADTO_RESP_OKAY 2'h0
`define ADTO_RESP_SLVERR 2'h2

`endif

// ==== pkg/adto_pkg.sv ====
// types shared by the adaptive dead-time offset block
package adto_pkg;

   typedef logic [15:0] adto_time_t;

   typedef logic [2:0] adto_code_t;

   typedef enum logic {
      ADTO_BUS_IDLE,
      ADTO_BUS_ACK
   } adto_bus_state_t;

endpackage : adto_pkg

// ==== rtl/adto_top.sv ====
// adaptive dead-time offset logic with its avalon-mm register slave
// Function
// - three-bit threshold code in bits 2:0, zero code means zero threshold, linear.
// - below threshold apply edge offsets, otherwise pass nominal edge times unchanged.
// - polarity bit 7 for edge one, bit 3 for edge two; one means negative.
// - edge one magnitude from bits 6:4, 5 ns per code, 0 to 35 ns.
// - edge two magnitude from bits 2:0, 5 ns per code, 0 to 35 ns.
`timescale 1ns/1ps
`include "adto_defs.svh"

module adto_top
(
   input wire logic i_mclk,
   input wire logic i_rst,
   // avalon-mm slave
   input wire logic [9:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic [1:0] o_avs_response,
   output logic o_avs_waitrequest,
   // current sense reading from the sense adc logic
   input wire logic [7:0] i_secondary_current_sense,
   input wire logic i_secondary_current_sense_valid,
   // pwm engine side
   input wire logic i_period_start,
   input wire logic [15:0] i_edge1_nominal,
   input wire logic [15:0] i_edge2_nominal,
   output logic [15:0] o_edge1_adjusted,
   output logic [15:0] o_edge2_adjusted,
   output logic o_offsets_applied
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   adto_pkg::adto_bus_state_t bus_state_reg;
   adto_pkg::adto_bus_state_t bus_state_next;
   logic [7:0] threshold_reg;
   logic [7:0] edge_offsets_reg;
   logic [7:0] sense_reg;
   logic applied_reg;
   logic [31:0] readdata_reg;
   logic [1:0] response_reg;
   adto_pkg::adto_time_t edge1_reg;
   adto_pkg::adto_time_t edge2_reg;
   logic [7:0] word_index;
   logic bus_request;
   logic index_mapped;
   logic write_commit;
   logic [10:0] threshold_level;
   logic below_threshold;
   logic [31:0] read_value;
   adto_pkg::adto_time_t edge1_next;
   adto_pkg::adto_time_t edge2_next;

   ////////////////////////////////////////////////////////////////////////////
   // avalon-mm handshake: one wait cycle, then the answer

   assign word_index = i_avs_address[9:2];
   assign bus_request = i_avs_read | i_avs_write;
   assign index_mapped = (word_index == `ADTO_IDX_THRESHOLD) ||
                         (word_index == `ADTO_IDX_EDGE_OFFSETS) ||
                         (word_index == `ADTO_IDX_STATUS);
   assign write_commit = i_avs_write && (bus_state_reg == adto_pkg::ADTO_BUS_ACK);

   always_comb
   begin
      bus_state_next = bus_state_reg;
      case (bus_state_reg)
         adto_pkg::ADTO_BUS_IDLE:
         begin
            if (bus_request)
            begin
               bus_state_next = adto_pkg::ADTO_BUS_ACK;
            end
         end
         adto_pkg::ADTO_BUS_ACK:
         begin
            bus_state_next = adto_pkg::ADTO_BUS_IDLE;
         end
         default:
         begin
            bus_state_next = adto_pkg::ADTO_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         bus_state_reg <= adto_pkg::ADTO_BUS_IDLE;
      end
      else
      begin
         bus_state_reg <= bus_state_next;
      end
   end

   assign o_avs_waitrequest = bus_request && (bus_state_reg != adto_pkg::ADTO_BUS_ACK);

   ////////////////////////////////////////////////////////////////////////////
   // register file

   // threshold code kept with its reserved bits
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         threshold_reg <= `ADTO_THR_RESET;
      end
      else if (write_commit && i_avs_byteenable[0] &&
               (word_index == `ADTO_IDX_THRESHOLD))
      begin
         threshold_reg <= i_avs_writedata[7:0];
      end
   end

   // polarity and magnitude fields of both edges
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         edge_offsets_reg <= `ADTO_OFFSETS_RESET;
      end
      else if (write_commit && i_avs_byteenable[0] &&
               (word_index == `ADTO_IDX_EDGE_OFFSETS))
      begin
         edge_offsets_reg <= i_avs_writedata[7:0];
      end
   end

   always_comb
   begin
      read_value = 32'h00000000;
      case (word_index)
         `ADTO_IDX_THRESHOLD:
         begin
            read_value[7:0] = threshold_reg;
         end
         `ADTO_IDX_EDGE_OFFSETS:
         begin
            read_value[7:0] = edge_offsets_reg;
         end
         `ADTO_IDX_STATUS:
         begin
            read_value[`ADTO_ST_APPLIED_BIT] = applied_reg;
            read_value[`ADTO_ST_BELOW_BIT] = below_threshold;
         end
         default:
         begin
            read_value = 32'h00000000;
         end
      endcase
   end

   // answer is loaded in the wait cycle and stands while waitrequest is low
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         readdata_reg <= 32'h00000000;
         response_reg <= `ADTO_RESP_OKAY;
      end
      else if (bus_request && (bus_state_reg == adto_pkg::ADTO_BUS_IDLE))
      begin
         readdata_reg <= i_avs_read ? read_value : 32'h00000000;
         response_reg <= index_mapped ? `ADTO_RESP_OKAY : `ADTO_RESP_SLVERR;
      end
   end

   assign o_avs_readdata = readdata_reg;
   assign o_avs_response = response_reg;

   ////////////////////////////////////////////////////////////////////////////
   // light-load detection

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         sense_reg <= 8'hff;
      end
      else if (i_secondary_current_sense_valid)
      begin
         sense_reg <= i_secondary_current_sense;
      end
   end

   // threshold rises linearly with the code, zero code never trips
   assign threshold_level = 11'(threshold_reg[`ADTO_THR_CODE_MSB:`ADTO_THR_CODE_LSB]) *
                            11'(`ADTO_THR_STEP);
   // strictly below the threshold selects the offset timing
   assign below_threshold = {3'h0, sense_reg} < threshold_level;

   ////////////////////////////////////////////////////////////////////////////
   // edge timing

   // edge one shifted by its magnitude field in its polarity
   adto_edge_shift
   #(
      .STEP_TICKS(`ADTO_STEP_TICKS)
   )
   u_edge1_shift
   (
      .i_nominal(i_edge1_nominal),
      .i_negative(edge_offsets_reg[`ADTO_E1_POL_BIT]),
      .i_code(edge_offsets_reg[`ADTO_E1_MAG_MSB:`ADTO_E1_MAG_LSB]),
      .i_enable(below_threshold),
      .o_adjusted(edge1_next)
   );

   // edge two shifted by its magnitude field in its polarity
   adto_edge_shift
   #(
      .STEP_TICKS(`ADTO_STEP_TICKS)
   )
   u_edge2_shift
   (
      .i_nominal(i_edge2_nominal),
      .i_negative(edge_offsets_reg[`ADTO_E2_POL_BIT]),
      .i_code(edge_offsets_reg[`ADTO_E2_MAG_MSB:`ADTO_E2_MAG_LSB]),
      .i_enable(below_threshold),
      .o_adjusted(edge2_next)
   );

   // edges and the applied flag change only at a period start
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         edge1_reg <= 16'h0000;
         edge2_reg <= 16'h0000;
         applied_reg <= 1'b0;
      end
      else if (i_period_start)
      begin
         edge1_reg <= edge1_next;
         edge2_reg <= edge2_next;
         applied_reg <= below_threshold;
      end
   end

   assign o_edge1_adjusted = edge1_reg;
   assign o_edge2_adjusted = edge2_reg;
   assign o_offsets_applied = applied_reg;

endmodule : adto_top

////////////////////////////////////////////////////////////////////////////////
// one edge moved by a signed offset; clamps at both ends instead of wrapping

module adto_edge_shift
#(
   parameter int STEP_TICKS = `ADTO_STEP_TICKS
)
(
   input wire logic [15:0] i_nominal,
   input wire logic i_negative,
   input wire logic [2:0] i_code,
   input wire logic i_enable,
   output logic [15:0] o_adjusted
);

   logic [16:0] shift;
   logic [16:0] sum;

   assign shift = 17'(i_code) * 17'(STEP_TICKS);

   always_comb
   begin
      sum = 17'h00000;
      o_adjusted = i_nominal;
      if (i_enable)
      begin
         if (i_negative)
         begin
            if ({1'b0, i_nominal} < shift)
            begin
               o_adjusted = 16'h0000;
            end
            else
            begin
               sum = {1'b0, i_nominal} - shift;
               o_adjusted = sum[15:0];
            end
         end
         else
         begin
            sum = {1'b0, i_nominal} + shift;
            if (sum[16])
            begin
               o_adjusted = 16'hffff;
            end
            else
            begin
               o_adjusted = sum[15:0];
            end
         end
      end
   end

endmodule : adto_edge_shift

// ==== verif/adto_checker.sv ====
// port assertions of the dead-time block
`timescale 1ns/1ps
module adto_checker
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [9:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [1:0] o_avs_response,
   input wire logic o_avs_waitrequest,
   input wire logic i_period_start,
   input wire logic [15:0] i_edge1_nominal,
   input wire logic [15:0] o_edge1_adjusted,
   input wire logic [15:0] o_edge2_adjusted,
   input wire logic o_offsets_applied
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   logic [15:0] nom_reg;
   wire logic req = i_avs_read | i_avs_write;
   wire logic [15:0] d1 = o_edge1_adjusted - nom_reg;
   wire logic known = i_avs_address[9:3] == 7'h34 || i_avs_address[9:2] == 8'h70;
   always_ff @(posedge i_mclk)
      nom_reg <= i_period_start ? i_edge1_nominal : nom_reg;
   sequence s_plain; i_period_start ##1 !o_offsets_applied; endsequence
   sequence s_adj; i_period_start ##1 o_offsets_applied; endsequence
   a_one_wait: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("second wait cycle");
   a_map_resp: assert property (i_avs_read && !o_avs_waitrequest |->
      o_avs_response == (known ? 2'h0 : 2'h2)) else $error("bad response");
   a_plain_pass: assert property (s_plain |-> d1 == 16'h0)
      else $error("edge moved above threshold");
   a_offset_span: assert property (s_adj |-> d1 <= 16'h7 || d1 >= 16'hfff9)
      else $error("offset out of range");
   a_edge_hold: assert property (!i_period_start |=> $stable(o_edge1_adjusted)
      && $stable(o_edge2_adjusted)) else $error("edge moved mid period");
   a_flag_hold: assert property (!i_period_start |=> $stable(o_offsets_applied))
      else $error("flag moved mid period");
endmodule : adto_checker
bind adto_top adto_checker u_chk (.i_mclk, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write,
   .o_avs_response, .o_avs_waitrequest, .i_period_start, .i_edge1_nominal,
   .o_edge1_adjusted, .o_edge2_adjusted, .o_offsets_applied);

// ==== verif/adto_sense_model.sv ====
// current-sense source and switching-period timer
`timescale 1ns/1ps
module adto_sense_model
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [7:0] i_level,
   output logic [7:0] o_sense,
   output logic o_sense_valid,
   output logic o_period_start
);
   logic [2:0] cnt_reg;
   always_ff @(posedge i_mclk or posedge i_rst)
      if (i_rst) cnt_reg <= 3'h0;
      else cnt_reg <= cnt_reg + 3'h1;
   assign o_sense_valid = cnt_reg == 3'h2;
   // the reading is not held outside its pulse
   assign o_sense = o_sense_valid ? i_level : ~i_level;
   assign o_period_start = cnt_reg == 3'h5;
endmodule : adto_sense_model

// ==== verif/adto_top_bench.sv ====
// self-checking bench of the dead-time block
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin mismatches++; \
   $display("MISMATCH %s exp %h got %h", n, e, a); end end
module adto_top_bench;
   logic i_mclk = 0, i_rst = 1, i_avs_read = 0, i_avs_write = 0, ea, pend = 0;
   logic [9:0] i_avs_address = 0;
   logic [31:0] i_avs_writedata = 0, o_avs_readdata;
   logic [1:0] o_avs_response, st_exp;
   logic [3:0] be = 4'hf;
   logic o_avs_waitrequest, i_secondary_current_sense_valid, i_period_start, o_offsets_applied;
   logic [7:0] i_secondary_current_sense, level = 0, thr_m = 0, off_m = 0, sns_m = 8'hff;
   logic [15:0] i_edge1_nominal = 0, i_edge2_nominal = 0, o_edge1_adjusted, o_edge2_adjusted;
   logic [15:0] e1, e2;
   int mismatches = 0, checks = 0;
   wire logic bl = sns_m < thr_m[2:0] * 26;
   adto_top u_dut (.i_mclk, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write,
      .i_avs_writedata, .i_avs_byteenable(be), .o_avs_readdata, .o_avs_response,
      .o_avs_waitrequest, .i_secondary_current_sense, .i_secondary_current_sense_valid,
      .i_period_start, .i_edge1_nominal, .i_edge2_nominal, .o_edge1_adjusted,
      .o_edge2_adjusted, .o_offsets_applied);
   adto_sense_model u_sense (.i_mclk, .i_rst, .i_level(level),
      .o_sense(i_secondary_current_sense), .o_sense_valid(i_secondary_current_sense_valid),
      .o_period_start(i_period_start));
   initial forever #5 i_mclk = ~i_mclk;
   function automatic logic [15:0] adj(input int nom, input bit neg, input int mag, input bit on);
      int v;
      v = on ? (neg ? nom - mag : nom + mag) : nom;
      return v < 0 ? 16'h0 : v > 65535 ? 16'hffff : 16'(v);
   endfunction : adj
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : complete_run
   task automatic acc(input bit w, input logic [7:0] idx, input logic [7:0] d);
      int n;
      logic [7:0] x;
      @(posedge i_mclk);
      i_avs_read <= !w;
      i_avs_write <= w;
      i_avs_address <= {idx, 2'h0};
      i_avs_writedata <= {24'h0, d};
      n = 0;
      do @(posedge i_mclk); while (o_avs_waitrequest !== 1'b0 && ++n < 40);
      if (n >= 40) begin mismatches++; complete_run(); end
      i_avs_read <= 0;
      i_avs_write <= 0;
      if (w && be[0] && idx == 8'h68) thr_m <= d;
      if (w && be[0] && idx == 8'h69) off_m <= d;
      if (!w)
      begin
         x = idx == 8'h68 ? thr_m : idx == 8'h69 ? off_m : 8'h0;
         if (idx == 8'h70) x = {6'h0, st_exp};
         `CHK("resp", idx[7:1] == 7'h34 || idx == 8'h70 ? 2'h0 : 2'h2, o_avs_response)
         `CHK("data", 32'(x), o_avs_readdata)
      end
   endtask : acc
   // reference model of the edge timing, checked one clock after each period start
   always @(posedge i_mclk)
   begin
      if (pend)
      begin
         `CHK("edge1", e1, o_edge1_adjusted)
         `CHK("edge2", e2, o_edge2_adjusted)
         `CHK("applied", ea, o_offsets_applied)
      end
      pend <= i_period_start;
      // status as the slave captures it at the request edge
      st_exp <= {bl, ea};
      if (i_secondary_current_sense_valid) sns_m <= i_secondary_current_sense;
      if (i_period_start)
      begin
         ea <= bl;
         e1 <= adj(i_edge1_nominal, off_m[7], off_m[6:4], bl);
         e2 <= adj(i_edge2_nominal, off_m[3], off_m[2:0], bl);
      end
      i_edge1_nominal <= $urandom_range(0, 3) == 0 ? 16'h2 : 16'($urandom);
      i_edge2_nominal <= $urandom_range(0, 3) == 0 ? 16'hfffd : 16'($urandom);
   end
   initial
   begin
      void'($urandom(32'hf73e));
      repeat (16) @(posedge i_mclk);
      i_rst <= 0;
      acc(0, 8'h68, 0);
      acc(0, 8'h69, 0);
      acc(0, 8'h3f, 0);
      for (int c = 0; c < 8; c++)
      begin
         acc(1, 8'h68, 8'($urandom) & 8'hf8 | 8'(c));
         acc(1, 8'h69, 8'($urandom));
         acc(0, 8'h68, 0);
         acc(0, 8'h69, 0);
         level <= 8'(c * 26 - c % 2);
         repeat (40) @(posedge i_mclk);
         acc(0, 8'h70, 0);
      end
      // byte lane zero off: the write must be dropped
      be <= 4'($urandom) & 4'he;
      acc(1, 8'h69, 8'($urandom));
      be <= 4'hf;
      acc(0, 8'h69, 0);
      complete_run();
   end
endmodule : adto_top_bench
